//--- rst_self_test.sv
`timescale 1ns/10ps
`default_nettype none
module rst_self_test #(
  parameter int unsigned TEST_CYCLES = rst_pkg::SELF_TEST_CYC,
  parameter int unsigned TX_TO_CYCLES = rst_pkg::TX_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  // pins from outside the clock domain
  input  wire logic        i_master_clear_in,
  input  wire logic        i_powerup_test_enable_in,
  input  wire logic        i_transfer_grant_in,
  // configuration parameters
  input  wire logic [5:0]  i_auto_cfg,
  input  wire logic [5:0]  i_onfail_cfg,
  // protocol engine inputs: event pulses, plus levels i_tx_active, i_rtrt_wait, i_dma_req, i_msg_broadcast, i_msg_bus_b
  input  wire logic        i_msg_done,
  input  wire logic        i_msg_broadcast,
  input  wire logic        i_msg_bus_b,
  input  wire logic        i_loop_tx_word_valid,
  input  wire logic [15:0] i_loop_tx_word,
  input  wire logic        i_loop_rx_word_valid,
  input  wire logic [15:0] i_loop_rx_word,
  input  wire logic        i_loop_rx_error,
  input  wire logic        i_tx_active,
  input  wire logic        i_dma_req,
  input  wire logic        i_mc_init_self_test,
  input  wire logic        i_mc_tx_shutdown,
  input  wire logic        i_mc_inhibit_flag,
  input  wire logic        i_mc_tx_bit_word,
  input  wire logic        i_wc_high,
  input  wire logic        i_wc_low,
  input  wire logic        i_data_cmd_sync,
  input  wire logic        i_invalid_word,
  input  wire logic        i_rtrt_rx_err,
  input  wire logic        i_rtrt_wait,
  input  wire logic        i_rtrt_cmd_err,
  input  wire logic        i_rx_cmd_err,
  input  wire logic        i_status_sent,
  input  wire logic        i_selftest_fail,
  // status
  output logic [15:0]      o_built_in_test_result_word,
  output logic             o_bit_word_valid,
  output logic             o_terminal_flag,
  output logic             o_terminal_fail_out_n,
  output logic             o_transfer_request_out,
  output logic             o_self_test_busy,
  output logic             o_bus_response_inhibit,
  output logic             o_online,
  output logic             o_tx_enable_a,
  output logic             o_tx_enable_b
);
  initial begin
    if (TEST_CYCLES < 2 || TX_TO_CYCLES < 1) begin
      $error("rst_self_test counts too small");
    end
  end
  // two-flop synchronisers for pins
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
    end else begin
      s1_q <= {i_transfer_grant_in, i_powerup_test_enable_in, i_master_clear_in};
      s2_q <= s1_q;
    end
  end
  logic mclr_s;
  logic ten_s;
  logic grant_s;
  assign mclr_s  = s2_q[0];
  assign ten_s   = s2_q[1];
  assign grant_s = s2_q[2];

  // timers
  logic hs_exp;
  logic rt_exp;
  logic tx_exp;
  logic hs_run;
  assign hs_run = o_transfer_request_out & ~grant_s;
  rst_timer #(.LIMIT(rst_pkg::HS_TIMEOUT_CYC)) u_hs (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (hs_run),
    .o_expired (hs_exp)
  );
  rst_timer #(.LIMIT(rst_pkg::RT_PAIR_CYC)) u_rt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (i_rtrt_wait),
    .o_expired (rt_exp)
  );
  rst_timer #(.LIMIT(TX_TO_CYCLES)) u_tx (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_run     (i_tx_active),
    .o_expired (tx_exp)
  );

  // loopback compare of encoded and received replica
  logic [15:0] lb_word_q;
  logic [15:0] lb_word_d;
  logic        lb_pend_q;
  logic        lb_pend_d;
  logic        lb_bad_q;
  logic        lb_bad_d;
  logic        lb_fail_a;
  logic        lb_fail_b;
  always_comb begin
    lb_word_d = lb_word_q;
    lb_pend_d = lb_pend_q;
    lb_bad_d  = lb_bad_q;
    lb_fail_a = 1'b0;
    lb_fail_b = 1'b0;
    if (i_loop_tx_word_valid) begin
      lb_word_d = i_loop_tx_word;
      lb_pend_d = 1'b1;
    end
    if (i_loop_rx_word_valid) begin
      lb_pend_d = i_loop_tx_word_valid;
      if (i_loop_rx_error || i_loop_rx_word != lb_word_q || !lb_pend_q) begin // R02
        lb_bad_d = 1'b1;
      end
    end
    if (i_msg_done) begin
      if (!i_msg_broadcast && (lb_bad_d || lb_pend_d)) begin // R01
        lb_fail_a = ~i_msg_bus_b;
        lb_fail_b = i_msg_bus_b;
      end
      lb_bad_d  = 1'b0;
      lb_pend_d = 1'b0;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      lb_word_q <= 16'h0000;
      lb_pend_q <= 1'b0;
      lb_bad_q  <= 1'b0;
    end else begin
      lb_word_q <= lb_word_d;
      lb_pend_q <= lb_pend_d;
      lb_bad_q  <= lb_bad_d;
    end
  end

  // self-test sequencer
  localparam int unsigned TW = $clog2(TEST_CYCLES + 1);
  rst_pkg::rst_state_t st_q;
  rst_pkg::rst_state_t st_d;
  logic [TW-1:0] tc_q;
  logic [TW-1:0] tc_d;
  logic          mclr_q;
  logic          fail_q;
  logic          fail_d;
  logic          online_q;
  logic          online_d;
  logic          st_fail_evt;
  logic          mclr_rise;
  assign mclr_rise = mclr_s & ~mclr_q;
  always_comb begin
    st_d        = st_q;
    tc_d        = tc_q;
    fail_d      = fail_q;
    online_d    = online_q;
    st_fail_evt = 1'b0;
    case (st_q)
      rst_pkg::RST_IDLE: begin
        if (mclr_rise) begin
          if (ten_s && i_auto_cfg[rst_pkg::CFG_BIT_TEST]) begin // R06 R21
            st_d = rst_pkg::RST_TEST;
            tc_d = '0;
            fail_d = 1'b0;
          end else begin
            st_d = rst_pkg::RST_DONE;
            online_d = 1'b1;
          end
        end
      end
      rst_pkg::RST_TEST: begin
        if (i_selftest_fail) begin
          fail_d = 1'b1;
        end
        if (tc_q == TW'(TEST_CYCLES - 1)) begin // R04
          st_d = rst_pkg::RST_DONE;
          st_fail_evt = fail_d;
          online_d = ~fail_d | i_onfail_cfg[rst_pkg::CFG_BIT_ONFAIL]; // R22
        end else begin
          tc_d = tc_q + TW'(1);
        end
      end
      rst_pkg::RST_DONE: begin
        if (i_mc_init_self_test) begin // R07
          st_d = rst_pkg::RST_TEST;
          tc_d = '0;
          fail_d = 1'b0;
        end
      end
      default: begin
        st_d = rst_pkg::RST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_q     <= rst_pkg::RST_IDLE;
      tc_q     <= '0;
      mclr_q   <= 1'b0;
      fail_q   <= 1'b0;
      online_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      tc_q     <= tc_d;
      mclr_q   <= mclr_s;
      fail_q   <= fail_d;
      online_q <= online_d;
    end
  end

  // test word, sticky; report clears, set wins
  logic [15:0] word_q;
  logic [15:0] word_d;
  logic [15:0] set_v;
  logic        flag_q;
  logic        flag_d;
  logic        failn_q;
  logic        failn_d;
  logic        bwv_q;
  logic        bwv_d;
  logic        req_q;
  logic        req_d;
  logic        txa_q;
  logic        txa_d;
  logic        txb_q;
  logic        txb_d;
  always_comb begin
    set_v = 16'h0000;
    set_v[rst_pkg::B_TXTO]  = tx_exp;                               // R10
    set_v[rst_pkg::B_LOOPBACK_FAIL_BUS_B]  = lb_fail_b;                            // R11
    set_v[rst_pkg::B_LOOPBACK_FAIL_BUS_A]  = lb_fail_a;                            // R11
    set_v[rst_pkg::B_HSF]   = hs_exp;                               // R12
    set_v[rst_pkg::B_TX_SHUTDOWN_B_FLAG] = i_mc_tx_shutdown & ~i_msg_bus_b;      // R13
    set_v[rst_pkg::B_TX_SHUTDOWN_A_FLAG] = i_mc_tx_shutdown & i_msg_bus_b;       // R13
    set_v[rst_pkg::B_TERM_FLAG_INHIBITED] = i_mc_inhibit_flag;                    // R14
    set_v[rst_pkg::B_STF]   = st_fail_evt;                          // R08
    set_v[rst_pkg::B_WORD_COUNT_HIGH_FLAG]  = i_wc_high;                            // R15
    set_v[rst_pkg::B_WORD_COUNT_LOW_FLAG]  = i_wc_low;                             // R15
    set_v[rst_pkg::B_SYNC]  = i_data_cmd_sync;                      // R16
    set_v[rst_pkg::B_INVALID_WORD_FLAG]  = i_invalid_word;                       // R16
    set_v[rst_pkg::B_RT_PAIR_GAP_SYNC_ERROR] = i_rtrt_rx_err;                        // R17
    set_v[rst_pkg::B_RTTO]  = rt_exp;                               // R18
    set_v[rst_pkg::B_RTCWE] = i_rtrt_cmd_err;                       // R19
    set_v[rst_pkg::B_RX_CMD_WORD_ERROR] = i_rx_cmd_err;                         // R20
    bwv_d = 1'b0;
    word_d = word_q | set_v;                                        // R23
    if (i_mc_tx_bit_word && st_q != rst_pkg::RST_TEST) begin        // R09
      bwv_d  = 1'b1;
      word_d = set_v;                                               // R23
    end
    flag_d = flag_q;
    if (i_status_sent && !i_msg_broadcast) begin
      flag_d = 1'b0;
    end
    if (lb_fail_a || lb_fail_b || st_fail_evt) begin                // R03 R08
      flag_d = 1'b1;
    end
    failn_d = failn_q;
    if (st_fail_evt) begin
      failn_d = 1'b0;                                               // R08
    end else if (st_q == rst_pkg::RST_TEST && st_d == rst_pkg::RST_DONE) begin
      failn_d = 1'b1;
    end
    req_d = i_dma_req & online_q;
    txa_d = txa_q;
    txb_d = txb_q;
    if (i_mc_tx_shutdown) begin                                     // R13
      txa_d = ~i_msg_bus_b;
      txb_d = i_msg_bus_b;
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      word_q  <= rst_pkg::TEST_WORD_RST;
      bwv_q   <= 1'b0;
      flag_q  <= 1'b0;
      failn_q <= 1'b1;
      req_q   <= 1'b0;
      txa_q   <= 1'b1;
      txb_q   <= 1'b1;
    end else begin
      word_q  <= word_d;
      bwv_q   <= bwv_d;
      flag_q  <= flag_d;
      failn_q <= failn_d;
      req_q   <= req_d;
      txa_q   <= txa_d;
      txb_q   <= txb_d;
    end
  end

  // busy flag registered with next state
  logic busy_q;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (st_d == rst_pkg::RST_TEST);
    end
  end

  assign o_built_in_test_result_word = word_q;
  assign o_bit_word_valid      = bwv_q;
  assign o_terminal_flag       = flag_q;
  assign o_terminal_fail_out_n = failn_q;
  assign o_transfer_request_out = req_q;
  assign o_self_test_busy      = busy_q;
  assign o_bus_response_inhibit = busy_q; // R05
  assign o_online              = online_q;
  assign o_tx_enable_a         = txa_q;
  assign o_tx_enable_b         = txb_q;
endmodule // rst_self_test
`default_nettype wire

//--- rst_pkg.sv
// Operation
// [R01] run a loopback check after every non-broadcast message and judge its validity
// [R02] loopback judged from receiver decode of own transmission, separate from encoder
// [R03] loopback failure sets terminal flag for the next non-broadcast status word
// [R04] protocol self-test walks registers and fifo for about 32,000 clocks
// [R05] no response to bus messages while the protocol self-test runs
// [R06] power-up self-test only when enable input and parameter bit 5 are 1
// [R07] an initiate self-test mode command also starts the protocol self-test
// [R08] self-test failure sets terminal flag, test word bit 8, fail output low
// [R09] test word filled by hardware, 1 marks error, sent on transmit bit word
// [R10] bit 15 set when transmission exceeds 660.5 us timeout
// [R11] bit 14 on bus b loopback failure, bit 13 on bus a loopback failure
// [R12] bit 12 set when grant does not follow request within 10 us
// [R13] shutdown command disables inactive transmitter; bit 11 for bus a, 10 for b
// [R14] bit 9 set on inhibit terminal flag mode command
// [R15] bit 7 on too many data words, bit 6 on too few
// [R16] bit 5 on command sync in data word, bit 4 on invalid word
// [R17] bit 3 on rt pair gap, sync, format or address error as receiver
// [R18] bit 2 when transmitting terminal of rt pair exceeds about 17 us
// [R19] bit 1 when rt pair transmit command word is in error as receiver
// [R20] bit 0 when a received command word contains an error
// [R21] power-up test starts after master clear rises, only if both enables are 1
// [R22] parameter 0 goes online only on pass; 1 goes online even after failure
// [R23] test word bits clear on reset, stay set until reset or report
package rst_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SELF_TEST_CYC = 32000;
  localparam int unsigned HS_TIMEOUT_NS = 10000;
  localparam int unsigned HS_TIMEOUT_CYC = (HS_TIMEOUT_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned RT_PAIR_NS    = 17000;
  localparam int unsigned RT_PAIR_CYC   = (RT_PAIR_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned TX_TIMEOUT_PS = 660_500_000;
  localparam int unsigned TX_TIMEOUT_CYC = TX_TIMEOUT_PS / 10_000;
  localparam int unsigned CFG_BIT_TEST  = 5;
  localparam int unsigned CFG_BIT_ONFAIL = 5;
  localparam logic [15:0] TEST_WORD_RST = 16'h0000;
  localparam int unsigned B_TXTO  = 15;
  localparam int unsigned B_LOOPBACK_FAIL_BUS_B  = 14;
  localparam int unsigned B_LOOPBACK_FAIL_BUS_A  = 13;
  localparam int unsigned B_HSF   = 12;
  localparam int unsigned B_TX_SHUTDOWN_B_FLAG = 11;
  localparam int unsigned B_TX_SHUTDOWN_A_FLAG = 10;
  localparam int unsigned B_TERM_FLAG_INHIBITED = 9;
  localparam int unsigned B_STF   = 8;
  localparam int unsigned B_WORD_COUNT_HIGH_FLAG  = 7;
  localparam int unsigned B_WORD_COUNT_LOW_FLAG  = 6;
  localparam int unsigned B_SYNC  = 5;
  localparam int unsigned B_INVALID_WORD_FLAG  = 4;
  localparam int unsigned B_RT_PAIR_GAP_SYNC_ERROR = 3;
  localparam int unsigned B_RTTO  = 2;
  localparam int unsigned B_RTCWE = 1;
  localparam int unsigned B_RX_CMD_WORD_ERROR = 0;
  typedef enum logic [1:0] {
    RST_IDLE = 2'b00,
    RST_TEST = 2'b01,
    RST_DONE = 2'b10
  } rst_state_t;
endpackage

//--- rst_timer.sv
`timescale 1ns/10ps
`default_nettype none
// counts cycles while armed; pulses expired once the limit is reached
module rst_timer #(
  parameter int unsigned LIMIT = 1000
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_run,
  output logic      o_expired
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         exp_q;
  logic         exp_d;
  initial begin
    if (LIMIT < 1) begin
      $error("rst_timer limit must be at least 1");
    end
  end
  always_comb begin
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (!i_run) begin
      cnt_d = '0;
    end else if (cnt_q == W'(LIMIT - 1)) begin
      exp_d = 1'b1;
      cnt_d = W'(LIMIT);
    end else if (cnt_q != W'(LIMIT)) begin
      cnt_d = cnt_q + W'(1);
    end
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign o_expired = exp_q;
endmodule // rst_timer
`default_nettype wire

//--- rst_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// simple host: grants a transfer a set number of cycles after the request
module rst_host_model (
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // handshake
  input  wire logic i_transfer_request_out,
  input  wire logic [15:0] i_delay,
  output logic             o_transfer_grant_in
);
  int   cnt_d, cnt_q;
  logic gnt_d, gnt_q;
  always_comb begin
    cnt_d = i_transfer_request_out ? cnt_q + 1 : 0;
    gnt_d = i_transfer_request_out && (cnt_q >= i_delay);
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 0;
      gnt_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      gnt_q <= gnt_d;
    end
  end
  assign o_transfer_grant_in = gnt_q;
endmodule // rst_host_model
`default_nettype wire

//--- rst_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module rst_checker #(
  parameter int unsigned TEST_CYCLES = 50
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_dma_req,
  input  wire logic        i_msg_bus_b,
  input  wire logic        i_mc_init_self_test,
  input  wire logic        i_mc_tx_shutdown,
  input  wire logic        i_mc_inhibit_flag,
  input  wire logic        i_mc_tx_bit_word,
  input  wire logic        i_wc_high,
  input  wire logic        i_rx_cmd_err,
  input  wire logic [15:0] o_built_in_test_result_word,
  input  wire logic        o_terminal_flag,
  input  wire logic        o_terminal_fail_out_n,
  input  wire logic        o_transfer_request_out,
  input  wire logic        o_self_test_busy,
  input  wire logic        o_bus_response_inhibit,
  input  wire logic        o_online,
  input  wire logic        o_tx_enable_b
);
  logic [15:0] bcnt_d, bcnt_q;
  always_comb begin
    bcnt_d = o_self_test_busy ? bcnt_q + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      bcnt_q <= 16'h0000;
    end else begin
      bcnt_q <= bcnt_d;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  cmd_err_bit_a:
    assert property (i_rx_cmd_err |=> o_built_in_test_result_word[0]) else $error("bit 0 not set");
  count_high_bit_a:
    assert property (i_wc_high |=> o_built_in_test_result_word[7]) else $error("bit 7 not set");
  inhibit_bit_a:
    assert property (i_mc_inhibit_flag |=> o_built_in_test_result_word[9]) else $error("bit 9 not set");
  shutdown_a_a:
    assert property (i_mc_tx_shutdown && !i_msg_bus_b |=> o_built_in_test_result_word[11]
      && !o_tx_enable_b) else $error("bus a shutdown wrong");
  word_sticky_a:
    assert property (!i_mc_tx_bit_word |=> (o_built_in_test_result_word
      & $past(o_built_in_test_result_word)) == $past(o_built_in_test_result_word))
      else $error("test word bit lost");
  busy_quiet_a:
    assert property (i_mc_init_self_test && !o_self_test_busy |=> o_bus_response_inhibit)
      else $error("responds in test");
  test_start_a:
    assert property (i_mc_init_self_test && !o_self_test_busy |-> ##[1:4] o_self_test_busy)
      else $error("self-test not started");
  test_length_a:
    assert property ($fell(o_self_test_busy) |-> bcnt_q >= TEST_CYCLES - 1
      && bcnt_q <= TEST_CYCLES + 2) else $error("self-test length wrong");
  fail_flags_a:
    assert property ($fell(o_terminal_fail_out_n) |-> o_built_in_test_result_word[8]
      && o_terminal_flag) else $error("fail flags missing");
  request_follow_a:
    assert property (i_dma_req && o_online |=> o_transfer_request_out) else $error("no request");
endmodule // rst_checker
bind rst_self_test rst_checker #(.TEST_CYCLES(TEST_CYCLES)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_dma_req(i_dma_req), .i_msg_bus_b(i_msg_bus_b),
  .i_mc_init_self_test(i_mc_init_self_test), .i_mc_tx_shutdown(i_mc_tx_shutdown),
  .i_mc_inhibit_flag(i_mc_inhibit_flag), .i_mc_tx_bit_word(i_mc_tx_bit_word),
  .i_wc_high(i_wc_high), .i_rx_cmd_err(i_rx_cmd_err),
  .o_built_in_test_result_word(o_built_in_test_result_word),
  .o_terminal_flag(o_terminal_flag), .o_terminal_fail_out_n(o_terminal_fail_out_n),
  .o_transfer_request_out(o_transfer_request_out), .o_self_test_busy(o_self_test_busy),
  .o_bus_response_inhibit(o_bus_response_inhibit), .o_online(o_online),
  .o_tx_enable_b(o_tx_enable_b));
`default_nettype wire

//--- remote_terminal_self_test_bench.sv
`timescale 1ns/10ps
`default_nettype none
module remote_terminal_self_test_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        mclr = 1'b0;
  logic        bus_b = 1'b0;
  logic        bcast = 1'b0;
  logic        rxerr = 1'b0;
  logic        txv = 1'b0;
  logic        rxv = 1'b0;
  logic [15:0] txw = 16'h0000;
  logic [15:0] rxw = 16'h0000;
  logic        txa = 1'b0;
  logic        dreq = 1'b0;
  logic        rwait = 1'b0;
  logic [13:0] ev = 14'h0000;
  logic        grant, bwv, tflag, fail_n, treq, busy, inh, online, txe_a, txe_b;
  logic [15:0] word;
  logic [15:0] hdelay = 16'h0014;
  int          fail_count = 0;
  int          n_tests = 0;
  int          bitmap [8] = '{0, 1, 3, 4, 5, 6, 7, 9};
  always #5 clk = ~clk;
  rst_self_test #(.TEST_CYCLES(50), .TX_TO_CYCLES(20)) dut (
    .i_clk_sys(clk), .i_rst(rst), .i_master_clear_in(mclr), .i_powerup_test_enable_in(1'b1),
    .i_transfer_grant_in(grant), .i_auto_cfg(6'h3f), .i_onfail_cfg(6'h3f),
    .i_msg_done(ev[11]), .i_msg_broadcast(bcast), .i_msg_bus_b(bus_b),
    .i_loop_tx_word_valid(txv), .i_loop_tx_word(txw), .i_loop_rx_word_valid(rxv),
    .i_loop_rx_word(rxw), .i_loop_rx_error(rxerr), .i_tx_active(txa), .i_dma_req(dreq),
    .i_mc_init_self_test(ev[9]), .i_mc_tx_shutdown(ev[8]), .i_mc_inhibit_flag(ev[7]),
    .i_mc_tx_bit_word(ev[10]), .i_wc_high(ev[6]), .i_wc_low(ev[5]), .i_data_cmd_sync(ev[4]),
    .i_invalid_word(ev[3]), .i_rtrt_rx_err(ev[2]), .i_rtrt_wait(rwait),
    .i_rtrt_cmd_err(ev[1]), .i_rx_cmd_err(ev[0]), .i_status_sent(ev[13]),
    .i_selftest_fail(ev[12]), .o_built_in_test_result_word(word), .o_bit_word_valid(bwv),
    .o_terminal_flag(tflag), .o_terminal_fail_out_n(fail_n), .o_transfer_request_out(treq),
    .o_self_test_busy(busy), .o_bus_response_inhibit(inh), .o_online(online),
    .o_tx_enable_a(txe_a), .o_tx_enable_b(txe_b));
  rst_host_model host (.i_clk_sys(clk), .i_rst(rst), .i_transfer_request_out(treq),
    .i_delay(hdelay), .o_transfer_grant_in(grant));
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic fire(input int k);
    ev[k] = 1'b1;
    tick(1);
    ev[k] = 1'b0;
    tick(1);
  endtask
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 200 && busy !== lvl; i++) tick(1);
    if (busy !== lvl) begin
      check("busy wait", {15'h0000, busy}, {15'h0000, lvl});
      end_sim();
    end
  endtask
  task automatic t_powerup();
    check("reset word", word, 16'h0000);
    check("reset pins", {12'h000, fail_n, txe_a, txe_b, online}, 16'h000e);
    mclr = 1'b1;
    wait_busy(1'b1);
    check("inhibit", {15'h0000, inh}, 16'h0001);
    fire(12);
    wait_busy(1'b0);
    check("fail word", word, 16'h0100);
    check("fail pins", {13'h0000, fail_n, tflag, online}, 16'h0003);
    fire(10);
    fire(13);
    check("flag cleared", {15'h0000, tflag}, 16'h0000);
  endtask
  task automatic t_loop(input logic b, input logic [15:0] rx, input logic [15:0] exp);
    bus_b = b;
    txw = 16'h5a3c;
    txv = 1'b1;
    tick(1);
    txv = 1'b0;
    rxw = rx;
    rxv = 1'b1;
    tick(1);
    rxv = 1'b0;
    fire(11);
    tick(1);
    check("loopback word", word, exp);
  endtask
  task automatic t_qualifiers();
    bcast = 1'b1;
    t_loop(1'b0, 16'h0000, 16'h0000);
    fire(13);
    check("broadcast flag", {15'h0000, tflag}, 16'h0000);
    bcast = 1'b0;
    rxerr = 1'b1;
    t_loop(1'b1, 16'h5a3c, 16'h4000);
    rxerr = 1'b0;
    bcast = 1'b1;
    fire(13);
    check("flag kept", {15'h0000, tflag}, 16'h0001);
    bcast = 1'b0;
    fire(13);
    check("flag next", {15'h0000, tflag}, 16'h0000);
    fire(10);
  endtask
  task automatic t_events();
    int k;
    logic [15:0] exp;
    exp = 16'h0000;
    for (k = 0; k < 8; k++) begin
      fire(k);
      exp[bitmap[k]] = 1'b1;
      check("event word", word, exp);
    end
    ev[10] = 1'b1;
    tick(1);
    check("report strobe", {15'h0000, bwv}, 16'h0001);
    ev[10] = 1'b0;
    tick(1);
    check("report clear", word, 16'h0000);
  endtask
  task automatic t_timers();
    dreq = 1'b1;
    tick(40);
    check("request", {15'h0000, treq}, 16'h0001);
    dreq = 1'b0;
    tick(5);
    check("grant in time", word, 16'h0000);
    hdelay = 16'h044c;
    dreq = 1'b1;
    tick(1060);
    dreq = 1'b0;
    check("grant late", word, 16'h1000);
    rwait = 1'b1;
    tick(1750);
    rwait = 1'b0;
    tick(2);
    check("pair timeout", word, 16'h1004);
    txa = 1'b1;
    tick(25);
    txa = 1'b0;
    check("tx timeout", word, 16'h9004);
    fire(10);
  endtask
  initial begin
    tick(3);
    rst = 1'b0;
    tick(1);
    t_powerup();
    t_loop(1'b0, 16'h5a3c, 16'h0000);
    check("good loop flag", {15'h0000, tflag}, 16'h0000);
    t_loop(1'b1, 16'h5a3d, 16'h4000);
    check("bad loop flag", {15'h0000, tflag}, 16'h0001);
    fire(13);
    t_loop(1'b0, 16'h0000, 16'h6000);
    fire(13);
    fire(10);
    t_qualifiers();
    t_events();
    t_timers();
    fire(6);
    fire(9);
    wait_busy(1'b1);
    fire(10);
    wait_busy(1'b0);
    check("report refused", word, 16'h0080);
    fire(10);
    bus_b = 1'b0;
    fire(8);
    check("shutdown a", {12'h000, word[11:10], txe_a, txe_b}, 16'h000a);
    bus_b = 1'b1;
    fire(8);
    check("shutdown b", {13'h0000, word[11:10], txe_a}, 16'h0006);
    end_sim();
  end
endmodule // remote_terminal_self_test_bench
`default_nettype wire
